/* File: core/dasg_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module dasg_decode (
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	input  wire dasg_pkg::dasg_dec_e  mode,
	input  wire logic [7:0]           page,
	input  wire logic [1:0]           min_sel,
	input  wire logic                 ale,
	input  wire logic                 cyc,
	input  wire logic [7:0]           ad_o,
	input  wire logic [7:0]           addr_hi,
	output logic                      das_cs_n,
	output logic [4:0]                das_addr,
	output logic                      das_ale,
	output logic [7:1]                periph_sel_n
);
	import dasg_pkg::*;
	logic [7:0] latched;
	logic [7:0] next_latched;
	logic [7:0] lo;
	logic [7:0] dec;
	logic       page_hit;
	logic       min_bit;
	// address latch, transparent while the strobe is high
	always_comb
	begin
		next_latched = ale ? ad_o : latched;
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			latched <= 8'h00;
		else
			latched <= next_latched;
	end
	// select decode per variant
	always_comb
	begin
		lo = (mode == DEC_COMPLETE) ? next_latched : ad_o;
		page_hit = (mode != DEC_COMPLETE) || (addr_hi == page);
		dec = page_hit ? dec3to8(lo[7:5]) : 8'h00;
		case (min_sel)
			2'd0:    min_bit = lo[5];
			2'd1:    min_bit = lo[6];
			default: min_bit = lo[7];
		endcase
		if (!cyc)
			das_cs_n = 1'b1;
		else if (mode == DEC_MINIMAL)
			das_cs_n = min_bit;
		else
			das_cs_n = ~dec[0];
		periph_sel_n = (mode == DEC_MINIMAL) ? 7'h7F : ~(dec[7:1] & {7{cyc}});
		das_addr = lo[4:0];
		das_ale = (mode == DEC_COMPLETE) ? 1'b1 : ale;
	end
	cs_page_a: assert property (@(posedge sys_clk) disable iff (srst)
		(!das_cs_n && mode == DEC_COMPLETE) |-> (addr_hi == page && lo[7:5] == 3'd0))
		else $error("select outside converter page");
	cs_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
		!cyc |-> das_cs_n)
		else $error("select active outside access");
endmodule // dasg_decode
`default_nettype wire

/* File: core/dasg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dasg_host (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [7:0]       ad_o,
	output logic             ad_oe,
	input  wire logic [7:0]  ad_i,
	output logic [7:0]       addr_hi,
	output logic             ale,
	output logic             rd_n,
	output logic             wr_n,
	output logic             program_fetch_strobe_n,
	output logic             das_clk,
	output logic             bus_width_select,
	output logic             das_cs_n,
	output logic [4:0]       das_addr,
	output logic             das_ale,
	output logic [7:1]       periph_sel_n,
	input  wire logic        interrupt_request_out_n
);
	import dasg_pkg::*;
	logic [31:0] ctrl, next_ctrl, ptr, next_ptr, wdat, next_wdat;
	logic [15:0] rdat, next_rdat;
	logic        pend, next_pend, sleep, next_sleep, pdown, next_pdown;
	logic        int_q, next_int_q, byte_sel, next_byte_sel;
	logic [3:0]  tmr, next_tmr;
	dasg_state_e state, next_state;
	logic [7:0]  next_ad_o, next_addr_hi;
	logic        next_ad_oe, next_ale, next_rd_n, next_wr_n, next_program_fetch_strobe_n;
	logic        cyc, next_cyc, next_das_clk;
	logic [2:0]  dcnt, next_dcnt;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        aw_hs, ar_hs, go, int_edge, sts_read;
	logic [15:0] baddr;
	logic [7:0]  wbyte;
	// register bus handshakes
	assign aw_hs = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign ar_hs = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_awready = aw_hs;
	assign s_axi_wready = aw_hs;
	assign s_axi_arready = ar_hs;
	assign bus_width_select = 1'b1;
	assign sts_read = ar_hs && s_axi_araddr[7:2] == REG_STATUS[7:2];
	assign int_edge = int_q & ~interrupt_request_out_n;
	assign baddr = ptr[15:0] + {15'd0, byte_sel};
	assign wbyte = byte_sel ? wdat[15:8] : wdat[7:0];
	// register writes, reads and power bits
	always_comb
	begin
		next_ctrl = ctrl;
		next_ptr = ptr;
		next_wdat = wdat;
		next_sleep = sleep;
		next_pdown = pdown;
		next_bvalid = s_axi_bvalid & ~s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid & ~s_axi_rready;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		next_int_q = interrupt_request_out_n;
		go = 1'b0;
		if (aw_hs)
		begin
			next_bvalid = 1'b1;
			next_bresp = RESP_OK;
			case (s_axi_awaddr[7:2])
				REG_CTRL[7:2]:
				begin
					next_ctrl = merge(ctrl, s_axi_wdata, s_axi_wstrb);
					next_ctrl[CTRL_GO] = 1'b0;
					go = s_axi_wstrb[0] & s_axi_wdata[CTRL_GO]
						& state == ST_IDLE & ~sleep & ~pdown;
				end
				REG_PTR[7:2]:   next_ptr = merge(ptr, s_axi_wdata, s_axi_wstrb);
				REG_WDATA[7:2]: next_wdat = merge(wdat, s_axi_wdata, s_axi_wstrb);
				REG_STATUS[7:2]: ;
				REG_PWR[7:2]:
				if (s_axi_wstrb[0])
				begin
					next_sleep = sleep | s_axi_wdata[PWR_SLEEP];
					next_pdown = pdown | s_axi_wdata[PWR_PDOWN];
				end
				default: next_bresp = RESP_ERR;
			endcase
		end
		if (sleep && pend && ctrl[CTRL_INTEN])
			next_sleep = 1'b0;
		// pending flag: the edge wins over the automatic clear
		next_pend = pend;
		if (sts_read)
			next_pend = 1'b0;
		if (int_edge)
			next_pend = 1'b1;
		if (ar_hs)
		begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OK;
			next_rdata = 32'h0000_0000;
			case (s_axi_araddr[7:2])
				REG_CTRL[7:2]:  next_rdata = ctrl;
				REG_PTR[7:2]:   next_rdata = {16'h0000, ptr[15:0]};
				REG_WDATA[7:2]: next_rdata = {16'h0000, wdat[15:0]};
				REG_STATUS[7:2]:
				begin
					next_rdata[STS_BUSY] = state != ST_IDLE;
					next_rdata[STS_PEND] = pend;
					next_rdata[STS_IDLE] = sleep;
					next_rdata[STS_PDOWN] = pdown;
					next_rdata[STS_RDATA +: 16] = rdat;
				end
				REG_PWR[7:2]:   next_rdata[PWR_SLEEP +: 2] = {pdown, sleep};
				default:        next_rresp = RESP_ERR;
			endcase
		end
	end
	// external bus cycle sequencer, two byte transfers per access
	always_comb
	begin
		next_state = state;
		next_tmr = tmr;
		next_byte_sel = byte_sel;
		next_rdat = rdat;
		next_ad_o = ad_o;
		next_ad_oe = ad_oe;
		next_addr_hi = addr_hi;
		next_ale = 1'b0;
		next_rd_n = 1'b1;
		next_wr_n = 1'b1;
		next_cyc = cyc;
		case (state)
			ST_IDLE:
			if (go)
			begin
				next_state = ST_ALE;
				next_byte_sel = 1'b0;
				next_tmr = 4'(ALE_CYC - 1);
				next_ale = 1'b1;
				next_ad_o = ptr[7:0];
				next_addr_hi = ptr[15:8];
				next_ad_oe = 1'b1;
				next_cyc = 1'b1;
			end
			ST_ALE:
			if (tmr == 4'd0)
			begin
				next_state = ST_STROBE;
				next_tmr = 4'(STB_CYC - 1);
				if (ctrl[CTRL_WRITE])
				begin
					next_ad_o = wbyte;
					next_wr_n = 1'b0;
				end
				else
				begin
					next_ad_oe = 1'b0;
					next_rd_n = 1'b0;
				end
			end
			else
			begin
				next_tmr = tmr - 4'd1;
				next_ale = 1'b1;
			end
			ST_STROBE:
			if (tmr == 4'd0)
			begin
				next_state = ST_GAP;
				next_tmr = 4'(GAP_CYC - 1);
				if (!ctrl[CTRL_WRITE])
				begin
					if (byte_sel)
						next_rdat[15:8] = ad_i;
					else
						next_rdat[7:0] = ad_i;
				end
			end
			else
			begin
				next_tmr = tmr - 4'd1;
				next_rd_n = rd_n;
				next_wr_n = wr_n;
			end
			ST_GAP:
			begin
				next_ad_oe = 1'b0;
				next_cyc = 1'b0;
				if (tmr != 4'd0)
					next_tmr = tmr - 4'd1;
				else if (!byte_sel)
				begin
					next_state = ST_ALE;
					next_byte_sel = 1'b1;
					next_tmr = 4'(ALE_CYC - 1);
					next_ale = 1'b1;
					next_ad_o = baddr[7:0] + 8'd1;
					next_addr_hi = baddr[15:8] + {7'd0, &baddr[7:0]};
					next_ad_oe = 1'b1;
					next_cyc = 1'b1;
				end
				else
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		next_program_fetch_strobe_n = 1'b1;
		if (pdown)
		begin
			next_state = state;
			next_tmr = tmr;
			next_ale = 1'b0;
			next_program_fetch_strobe_n = 1'b0;
			next_rd_n = rd_n;
			next_wr_n = wr_n;
		end
		else if (sleep && state == ST_IDLE)
			next_ale = 1'b1;
	end
	// converter clock divider, stopped in power down
	always_comb
	begin
		if (pdown)
			next_dcnt = 3'd0;
		else if (dcnt == 3'(CLK_DIV - 1))
			next_dcnt = 3'd0;
		else
			next_dcnt = dcnt + 3'd1;
		next_das_clk = ~pdown && next_dcnt < 3'(CLK_HIGH);
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ctrl <= CTRL_RST;
			ptr <= WORD_RST;
			wdat <= WORD_RST;
			rdat <= 16'h0000;
			pend <= 1'b0;
			sleep <= 1'b0;
			pdown <= 1'b0;
			int_q <= 1'b1;
			state <= ST_IDLE;
			tmr <= 4'd0;
			byte_sel <= 1'b0;
			ad_o <= 8'h00;
			ad_oe <= 1'b0;
			addr_hi <= 8'h00;
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			program_fetch_strobe_n <= 1'b1;
			cyc <= 1'b0;
			dcnt <= 3'd0;
			das_clk <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OK;
			s_axi_rdata <= 32'h0000_0000;
		end
		else
		begin
			ctrl <= next_ctrl;
			ptr <= next_ptr;
			wdat <= next_wdat;
			rdat <= next_rdat;
			pend <= next_pend;
			sleep <= next_sleep;
			pdown <= next_pdown;
			int_q <= next_int_q;
			state <= next_state;
			tmr <= next_tmr;
			byte_sel <= next_byte_sel;
			ad_o <= next_ad_o;
			ad_oe <= next_ad_oe;
			addr_hi <= next_addr_hi;
			ale <= next_ale;
			rd_n <= next_rd_n;
			wr_n <= next_wr_n;
			program_fetch_strobe_n <= next_program_fetch_strobe_n;
			cyc <= next_cyc;
			dcnt <= next_dcnt;
			das_clk <= next_das_clk;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end
	end
	// select decode and converter address
	dasg_decode u_decode (
		.sys_clk      (sys_clk),
		.srst         (srst),
		.mode         (dasg_dec_e'(ctrl[CTRL_MODE +: 2])),
		.page         (ctrl[CTRL_PAGE +: 8]),
		.min_sel      (ctrl[CTRL_MINSEL +: 2]),
		.ale          (ale),
		.cyc          (cyc),
		.ad_o         (ad_o),
		.addr_hi      (addr_hi),
		.das_cs_n     (das_cs_n),
		.das_addr     (das_addr),
		.das_ale      (das_ale),
		.periph_sel_n (periph_sel_n)
	);
	// checks on the bus and power behaviour
	strobe_excl_a: assert property (@(posedge sys_clk) disable iff (srst)
		!(!rd_n && !wr_n))
		else $error("read and write strobes both low");
	ale_width_a: assert property (@(posedge sys_clk) disable iff (srst)
		($rose(ale) && state != ST_IDLE) |-> ale[*4] ##1 !ale)
		else $error("address strobe width wrong");
	rd_width_a: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(rd_n) |-> !rd_n[*8] ##1 rd_n)
		else $error("read strobe width wrong");
	pdown_pins_a: assert property (@(posedge sys_clk) disable iff (srst)
		pdown |=> (!ale && !program_fetch_strobe_n && !das_clk))
		else $error("power down pins not held low");
	idle_pins_a: assert property (@(posedge sys_clk) disable iff (srst)
		(sleep && !pdown && state == ST_IDLE) |=> (ale && program_fetch_strobe_n))
		else $error("idle pins not held high");
	int_set_a: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(interrupt_request_out_n) |=> pend)
		else $error("interrupt edge not latched");
	int_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
		(sts_read && !int_edge) |=> !pend)
		else $error("pending flag not cleared on vectoring");
	idle_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
		(sleep && pend && ctrl[CTRL_INTEN]) |=> !sleep)
		else $error("idle not ended by interrupt");
	clk_rate_a: assert property (@(posedge sys_clk) disable iff (srst)
		($rose(das_clk) && !pdown) |-> ##5 (das_clk || pdown))
		else $error("converter clock period wrong");
	two_byte_c: cover property (@(posedge sys_clk) disable iff (srst)
		(state == ST_GAP && byte_sel) ##1 state == ST_IDLE);
	write_c: cover property (@(posedge sys_clk) disable iff (srst)
		$fell(wr_n) && !das_cs_n);
	wake_c: cover property (@(posedge sys_clk) disable iff (srst)
		$fell(sleep));
endmodule // dasg_host
`default_nettype wire

/* File: core/dasg_pkg.sv */
// Overview of operation
// - software uses full sixteen bit pointer
// - simple mode passes address strobe to converter
// - other peripherals should latch their own selects
// - byte-wide access, sixteen bits as two bytes
// - interrupt zero edge triggered, sole enabled source
// - pending flag clears automatically when vectored
// - converter clock stops in power down
// - idle mode keeps converter clock running
// - idle holds strobes high, oscillator running
// - power down holds strobes low, reset exits
// - enabled interrupt ends idle, clears sleep bit
// - shared converter clock runs at 8 MHz
package dasg_pkg;
	// register offsets
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_PTR    = 8'h04;
	localparam logic [7:0]  REG_WDATA  = 8'h08;
	localparam logic [7:0]  REG_STATUS = 8'h0C;
	localparam logic [7:0]  REG_PWR    = 8'h10;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] WORD_RST   = 32'h0000_0000;
	// field positions
	localparam int CTRL_GO      = 0;
	localparam int CTRL_WRITE   = 1;
	localparam int CTRL_MODE    = 2;
	localparam int CTRL_MINSEL  = 4;
	localparam int CTRL_INTEN   = 6;
	localparam int CTRL_PAGE    = 8;
	localparam int STS_BUSY     = 0;
	localparam int STS_PEND     = 1;
	localparam int STS_IDLE     = 2;
	localparam int STS_PDOWN    = 3;
	localparam int STS_RDATA    = 16;
	localparam int PWR_SLEEP    = 0;
	localparam int PWR_PDOWN    = 1;
	// converter address window
	localparam logic [15:0] DAS_WIN_LO = 16'h0000;
	localparam logic [15:0] DAS_WIN_HI = 16'h001F;
	// timing
	localparam int SYS_HZ   = 40_000_000;
	localparam int DAS_HZ   = 8_000_000;
	localparam int SYS_MHZ  = SYS_HZ / 1_000_000;
	localparam int CLK_DIV  = SYS_HZ / DAS_HZ;
	localparam int CLK_HIGH = CLK_DIV / 2;
	localparam int ALE_NS   = 100;
	localparam int STB_NS   = 200;
	localparam int ALE_CYC  = (ALE_NS * SYS_MHZ + 999) / 1000;
	localparam int STB_CYC  = (STB_NS * SYS_MHZ + 999) / 1000;
	localparam int GAP_CYC  = 1;
	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	typedef enum logic [1:0] {
		DEC_COMPLETE = 2'b00,
		DEC_SIMPLE   = 2'b01,
		DEC_MINIMAL  = 2'b10
	} dasg_dec_e;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ALE    = 2'b01,
		ST_STROBE = 2'b10,
		ST_GAP    = 2'b11
	} dasg_state_e;
	// one-hot 3-to-8 decode
	function automatic logic [7:0] dec3to8(input logic [2:0] a);
		dec3to8 = 8'h01 << a;
	endfunction
	// byte-enable merge of a register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction
endpackage

/* File: verif/dasg_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
// converter host port, byte wide, seen from its pins
module dasg_conv_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] ad_o,
	input  wire logic       ad_oe,
	output logic [7:0]      ad_i,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       das_cs_n,
	input  wire logic [4:0] das_addr,
	input  wire logic       das_ale,
	input  wire logic       das_clk,
	input  wire logic       irq_req,
	output logic            irq_n
);
	logic [7:0] mem [32];
	logic [4:0] la   = 5'h00;
	logic       lcs  = 1'b1;
	logic [7:0] last = 8'h00;
	logic       drv;
	initial for (int i = 0; i < 32; i++) mem[i] = 8'h00;
	// address and select held from the strobe, byte writes
	always @(posedge sys_clk)
	begin
		if (das_ale)
		begin
			la <= das_addr;
			lcs <= das_cs_n;
		end
		if (!wr_n && !lcs)
			mem[la] <= ad_o;
		last <= ad_i;
	end
	// released lines show the inverse of their last level
	assign drv = !rd_n && !lcs;
	assign ad_i = ad_oe ? ad_o : (drv ? mem[la] : ~last);
	// request only moves while the shared clock runs
	initial irq_n = 1'b1;
	always @(posedge das_clk)
		irq_n <= !irq_req;
endmodule // dasg_conv_model
`default_nettype wire

/* File: verif/tb_mcu_das_bus_decode_glue.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_das_bus_decode_glue;
	import dasg_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic sys_clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0;
	logic bready = 1'b0, arv = 1'b0, rready = 1'b0, irq_req = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid, ad_oe, ale, rd_n;
	logic wr_n, pfs_n, das_clk, bws, cs_n, das_ale, irq_n;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, m, v, seed = 32'h1e95_4a80;
	logic        pclr = 1'b0;
	logic [7:1]  psel_n, psel_low = 7'h00;
	logic [6:0]  c_per [11] = '{7'h00, 7'h00, 7'h00, 7'h01, 7'h00, 7'h00,
		7'h02, 7'h00, 7'h00, 7'h00, 7'h00};
	logic [7:0]  ad_o, ad_i, addr_hi;
	logic [4:0]  das_addr, a;
	logic [15:0] d, old;
	logic [15:0] c_ptr [11] = '{16'h0004, 16'h0104, 16'h001E, 16'h0020,
		16'h5A02, 16'hC306, 16'h0040, 16'hFF48, 16'h0020, 16'h0040, 16'h0060};
	logic [15:0] c_ctl [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h5A00, 16'h0004, 16'h0004, 16'h0008, 16'h0018, 16'h0018, 16'h0028};
	logic [10:0] c_sel = 11'h5B5;
	logic [31:0] exp_q [$], msk_q [$];
	logic [1:0]  rq [$];
	int num_errors = 0, comparisons = 0, cyc = 0, n;
	dasg_host dut (.sys_clk(sys_clk), .srst(srst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ad_o(ad_o),
		.ad_oe(ad_oe), .ad_i(ad_i), .addr_hi(addr_hi), .ale(ale),
		.rd_n(rd_n), .wr_n(wr_n), .program_fetch_strobe_n(pfs_n),
		.das_clk(das_clk), .bus_width_select(bws), .das_cs_n(cs_n),
		.das_addr(das_addr), .das_ale(das_ale), .periph_sel_n(psel_n),
		.interrupt_request_out_n(irq_n));
	dasg_conv_model model (.sys_clk(sys_clk), .ad_o(ad_o), .ad_oe(ad_oe),
		.ad_i(ad_i), .rd_n(rd_n), .wr_n(wr_n), .das_cs_n(cs_n),
		.das_addr(das_addr), .das_ale(das_ale), .das_clk(das_clk),
		.irq_req(irq_req), .irq_n(irq_n));
	initial forever #12.5 sys_clk = ~sys_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one write, valids held until taken, bready until bvalid
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt,
		input logic [1:0] r);
		rq.push_back(r);
		@(posedge sys_clk);
		awaddr <= ad;
		wdata <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do @(posedge sys_clk); while ((awready & wready) !== 1'b1);
		awv <= 1'b0;
		wv <= 1'b0;
		while (bvalid !== 1'b1) @(posedge sys_clk);
		bready <= 1'b0;
	endtask
	// one read; the note is what the watcher expects
	task automatic rd(input logic [7:0] ad, input logic [31:0] e,
		input logic [31:0] mk, input logic [1:0] r, output logic [31:0] q);
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
		rq.push_back(r);
		@(posedge sys_clk);
		araddr <= ad;
		arv <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arv <= 1'b0;
		while (rvalid !== 1'b1) @(posedge sys_clk);
		q = rdata;
		rready <= 1'b0;
	endtask
	task automatic wait_idle;
		logic [31:0] s;
		s = ALL;
		for (int i = 0; i < 20 && s[STS_BUSY] !== 1'b0; i++)
			rd(REG_STATUS, WORD_RST, WORD_RST, RESP_OK, s);
	endtask
	// watcher: each answer against the oldest note
	always @(posedge sys_clk)
	begin
		// other selects seen low during read strobes
		psel_low <= pclr ? 7'h00 : psel_low | (~psel_n & {7{~rd_n}});
		if (rvalid === 1'b1 && rready === 1'b1)
		begin
			m = msk_q.pop_front();
			check(rdata & m, exp_q.pop_front());
			check(32'(rresp), 32'(rq.pop_front()));
		end
		if (bvalid === 1'b1 && bready === 1'b1)
			check(32'(bresp), 32'(rq.pop_front()));
	end
	// hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			complete_run();
		end
	end
	// main sequence
	initial
	begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd(8'(i * 4), WORD_RST, ALL, RESP_OK, v);
		rd(8'h14, WORD_RST, ALL, RESP_ERR, v);
		wr(8'h14, ALL, RESP_ERR);
		check(32'({bws, cs_n, ale, rd_n, wr_n, pfs_n}), 32'h0000_0037);
		n = 0;
		repeat (10)
		begin
			@(posedge sys_clk);
			n += das_clk;
		end
		check(32'(n), 32'h0000_0004);
		// decode variants, byte pairs through the model
		for (int k = 0; k < 11; k++)
		begin
			seed = lfsr(seed);
			d = seed[15:0];
			a = c_ptr[k][4:0];
			old = {model.mem[a + 1], model.mem[a]};
			wr(REG_CTRL, {16'h0000, c_ctl[k]}, RESP_OK);
			wr(REG_PTR, {16'h0000, c_ptr[k]}, RESP_OK);
			wr(REG_WDATA, {16'h0000, d}, RESP_OK);
			wr(REG_CTRL, {16'h0000, c_ctl[k] | 16'h0003}, RESP_OK);
			if (k == 0)
				rd(REG_STATUS, ALL, 32'h0000_0001, RESP_OK, v);
			wait_idle();
			check({model.mem[a + 1], model.mem[a]}, c_sel[k] ? d : old);
			pclr <= 1'b1;
			wr(REG_CTRL, {16'h0000, c_ctl[k] | 16'h0001}, RESP_OK);
			pclr <= 1'b0;
			wait_idle();
			check(32'(psel_low), 32'(c_per[k]));
			if (c_sel[k])
				rd(REG_STATUS, {d, 16'h0000}, 32'hFFFF_0000, RESP_OK, v);
		end
		// masked request in sleep, then enabled wake-up
		wr(REG_CTRL, WORD_RST, RESP_OK);
		wr(REG_PWR, 32'h0000_0001, RESP_OK);
		@(posedge sys_clk);
		check(32'({ale, pfs_n}), 32'h0000_0003);
		irq_req <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rd(REG_STATUS, 32'h0000_0006, 32'h0000_000F, RESP_OK, v);
		irq_req <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rd(REG_STATUS, 32'h0000_0004, 32'h0000_000F, RESP_OK, v);
		wr(REG_CTRL, 32'h0000_0040, RESP_OK);
		irq_req <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rd(REG_STATUS, 32'h0000_0002, 32'h0000_000F, RESP_OK, v);
		rd(REG_STATUS, WORD_RST, 32'h0000_000F, RESP_OK, v);
		irq_req <= 1'b0;
		// power down freezes the shared clock, reset leaves it
		wr(REG_PWR, 32'h0000_0002, RESP_OK);
		repeat (2) @(posedge sys_clk);
		n = 0;
		repeat (10)
		begin
			@(posedge sys_clk);
			n += das_clk + ale + pfs_n;
		end
		check(32'(n), WORD_RST);
		rd(REG_STATUS, ALL, 32'h0000_0008, RESP_OK, v);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rd(REG_STATUS, WORD_RST, 32'h0000_000F, RESP_OK, v);
		complete_run();
	end
endmodule // tb_mcu_das_bus_decode_glue
`default_nettype wire
